// ---- src/ltu_pkg.sv ----
// package of the external line trigger unit: register map, field sizes, bus answers
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`default_nettype none

package ltu_pkg;

  // ==========================================================
  // sizes
  localparam int LTU_LINES = 19;
  localparam int LTU_DATA_W = 32;
  localparam int LTU_ADDR_W = 8;
  localparam int LTU_STRB_W = LTU_DATA_W / 8;

  // ==========================================================
  // register byte offsets
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_IRQ_EN = 8'h00;
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_EVT_EN = 8'h04;
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_RISE_EN = 8'h08;
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_FALL_EN = 8'h0C;
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_SOFT_TRIG = 8'h10;
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_PENDING = 8'h14;
  localparam logic [LTU_ADDR_W-1:0] LTU_OFF_LEVEL = 8'h18;

  // ==========================================================
  // reset values and bus answers
  localparam logic [LTU_DATA_W-1:0] LTU_CTRL_RST = 32'h0000_0000;
  localparam logic [LTU_STRB_W-1:0] LTU_FULL_STRB = 4'hF;
  localparam logic [1:0] LTU_RESP_OKAY = 2'h0;
  localparam logic [1:0] LTU_RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ---- src/ltu_line_if.sv ----
// per-line signals passed between the unit's control, edge and trigger modules
// assumes all parties run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface ltu_line_if #(
  parameter int NL = ltu_pkg::LTU_LINES
);
  logic [NL-1:0] rise;
  logic [NL-1:0] fall;
  logic [NL-1:0] level;
  logic [NL-1:0] irq_en;
  logic [NL-1:0] evt_en;
  logic [NL-1:0] rise_en;
  logic [NL-1:0] fall_en;
  logic [NL-1:0] soft_pulse;
  logic [NL-1:0] pend_clr;
  logic [NL-1:0] pend;
  logic [NL-1:0] evt;
  logic [NL-1:0] irq;

  modport edge_src (output rise, fall, level);
  modport trig (input rise, fall, irq_en, evt_en, rise_en, fall_en, soft_pulse, pend_clr,
                output pend, evt, irq);
  modport ctl (input level, pend, evt, irq,
               output irq_en, evt_en, rise_en, fall_en, soft_pulse, pend_clr);
endinterface

`default_nettype wire

// ---- src/ltu_edge_det.sv ----
// line synchroniser and edge detector: three flops per line, then rise and fall pulses
// assumes line inputs are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none

module ltu_edge_det #(
  parameter int NL = ltu_pkg::LTU_LINES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NL-1:0] line_in,
  ltu_line_if.edge_src lif
);
  import ltu_pkg::*;

  typedef struct packed {
    logic [NL-1:0] s1;
    logic [NL-1:0] s2;
    logic [NL-1:0] s3;
    logic [NL-1:0] lvl;
    logic [NL-1:0] rise;
    logic [NL-1:0] fall;
  } ltu_edge_st_t;

  ltu_edge_st_t st_ff;
  ltu_edge_st_t nxt_st;
  logic [NL-1:0] agree;

  // ==========================================================
  // next state: s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    nxt_st = st_ff;
    agree = ~(st_ff.s2 ^ st_ff.s3);
    nxt_st.s1 = line_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lvl = (agree & st_ff.s3) | (~agree & st_ff.lvl); // RULE_17
    nxt_st.rise = agree & st_ff.s3 & ~st_ff.lvl; // RULE_17
    nxt_st.fall = agree & ~st_ff.s3 & st_ff.lvl; // RULE_17
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lif.rise = st_ff.rise;
  assign lif.fall = st_ff.fall;
  assign lif.level = st_ff.lvl;

endmodule

`default_nettype wire

// ---- src/ltu_trig.sv ----
// trigger combiner: pending flags, event pulses and interrupt requests per line
// assumes one-cycle edge, soft-trigger and clear pulses from the same clock
`timescale 1ns/100ps
`default_nettype none

module ltu_trig #(
  parameter int NL = ltu_pkg::LTU_LINES
) (
  input wire logic clk,
  input wire logic sys_rst,
  ltu_line_if.trig lif
);
  import ltu_pkg::*;

  typedef struct packed {
    logic [NL-1:0] pend;
    logic [NL-1:0] evt;
    logic [NL-1:0] irq;
  } ltu_trig_st_t;

  ltu_trig_st_t st_ff;
  ltu_trig_st_t nxt_st;
  logic [NL-1:0] hit;

  // ==========================================================
  // a hit comes from an enabled edge or a fresh soft trigger
  always_comb begin
    nxt_st = st_ff;
    hit = (lif.rise & lif.rise_en) | (lif.fall & lif.fall_en) | lif.soft_pulse; // RULE_02 RULE_03 RULE_15
    // set beats clear so an edge in the clear cycle is kept
    nxt_st.pend = (st_ff.pend & ~lif.pend_clr) | (hit & lif.irq_en); // RULE_07 RULE_13
    nxt_st.evt = hit & lif.evt_en; // RULE_01 RULE_17
    nxt_st.irq = nxt_st.pend & lif.irq_en; // RULE_12 RULE_16
  end

  // state register; pending starts clear although software may not count on it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lif.pend = st_ff.pend;
  assign lif.evt = st_ff.evt;
  assign lif.irq = st_ff.irq;

endmodule

`default_nettype wire

// ---- src/ltu_top.sv ----
// external line trigger unit: AXI4-Lite register slave, line edge detection,
// pending flags, event pulses and per-line interrupt requests
// assumes lines are asynchronous pins and the bus master is AXI4-Lite compliant
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE_01: each line 0..18 has an event enable; 0 blocks its events.
// RULE_02: rising edges trigger only while the line's rising enable is set.
// RULE_03: falling edges trigger only while the line's falling enable is set.
// RULE_04: writing 1 to a soft trigger bit raises a request without an edge.
// RULE_05: writing 0 to a soft trigger bit withdraws the software request.
// RULE_06: each line keeps a pending bit, 1 once triggered.
// RULE_07: writing 1 clears a pending bit; writing 0 leaves it.
// RULE_08: software uses only full word accesses on these registers.
// RULE_09: software writes reserved bits 31..19 as zero.
// RULE_10: enable and soft trigger registers read zero after reset.
// RULE_11: software clears pending before enabling lines; reset value unspecified.
// RULE_12: each line has an interrupt enable gating its interrupt request.
// RULE_13: an interrupt trigger sets pending; an event-only trigger does not.
// RULE_14: a soft trigger raises the enabled request at once, no edge needed.
// RULE_15: rising and falling enables together respond to both transitions.
// RULE_16: interrupt request is pending AND interrupt enable, held until cleared.
// RULE_17: lines are synchronised first; each event is a one-cycle pulse.
module ltu_top #(
  parameter int NL = ltu_pkg::LTU_LINES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NL-1:0] line_in,
  output logic [NL-1:0] line_irq,
  output logic [NL-1:0] line_event,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ltu_pkg::LTU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [ltu_pkg::LTU_DATA_W-1:0] s_axi_wdata,
  input wire logic [ltu_pkg::LTU_STRB_W-1:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ltu_pkg::LTU_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ltu_pkg::LTU_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import ltu_pkg::*;

  // ==========================================================
  // state of the register slave and control registers
  typedef struct packed {
    logic [NL-1:0] irq_en;
    logic [NL-1:0] evt_en;
    logic [NL-1:0] rise_en;
    logic [NL-1:0] fall_en;
    logic [NL-1:0] soft_trig;
    logic [NL-1:0] soft_pulse;
    logic [NL-1:0] pend_clr;
    logic aw_held;
    logic [LTU_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [LTU_DATA_W-1:0] wdata;
    logic [LTU_STRB_W-1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [LTU_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ltu_top_st_t;

  ltu_top_st_t st_ff;
  ltu_top_st_t nxt_st;
  logic [NL-1:0] wd;
  logic wr_go;
  logic wr_full;
  logic rd_hit;
  logic [NL-1:0] rd_field;

  ltu_line_if #(.NL(NL)) lif ();

  // ==========================================================
  // submodules: synchroniser/edge detector and trigger combiner
  ltu_edge_det #(
    .NL(NL)
  ) u_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .line_in(line_in),
    .lif(lif.edge_src)
  );

  ltu_trig #(
    .NL(NL)
  ) u_trig (
    .clk(clk),
    .sys_rst(sys_rst),
    .lif(lif.trig)
  );

  // ==========================================================
  // control values handed to the trigger logic
  assign lif.irq_en = st_ff.irq_en;
  assign lif.evt_en = st_ff.evt_en;
  assign lif.rise_en = st_ff.rise_en;
  assign lif.fall_en = st_ff.fall_en;
  assign lif.soft_pulse = st_ff.soft_pulse;
  assign lif.pend_clr = st_ff.pend_clr;

  // ==========================================================
  // write channel: address and data may arrive in either order;
  // each is parked until its partner shows up, then one write is done
  always_comb begin
    nxt_st = st_ff;
    // one-cycle strobes drop by default
    nxt_st.soft_pulse = '0;
    nxt_st.pend_clr = '0;
    // bits above the line count are dropped, they are reserved
    wd = st_ff.wdata[NL-1:0];
    wr_go = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    // partial writes are refused: these registers are word-only
    wr_full = (st_ff.wstrb == LTU_FULL_STRB);
    rd_hit = 1'b1;
    rd_field = '0;

    // take the write address
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    // take the write data
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    // response accepted by the master
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // perform the write once both halves are parked
    if (wr_go) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = LTU_RESP_OKAY;
      if (!wr_full) begin
        nxt_st.bresp = LTU_RESP_SLVERR;
      end else begin
        case (st_ff.awaddr)
          LTU_OFF_IRQ_EN: begin
            nxt_st.irq_en = wd; // RULE_12
          end
          LTU_OFF_EVT_EN: begin
            nxt_st.evt_en = wd; // RULE_01
          end
          LTU_OFF_RISE_EN: begin
            nxt_st.rise_en = wd; // RULE_02
          end
          LTU_OFF_FALL_EN: begin
            nxt_st.fall_en = wd; // RULE_03
          end
          LTU_OFF_SOFT_TRIG: begin
            // only a 0->1 change fires, so rewriting 1 does not retrigger
            nxt_st.soft_trig = wd; // RULE_05
            nxt_st.soft_pulse = wd & ~st_ff.soft_trig; // RULE_04 RULE_14
          end
          LTU_OFF_PENDING: begin
            nxt_st.pend_clr = wd; // RULE_07
          end
          LTU_OFF_LEVEL: begin
            // read-only line levels, writes ignored
            nxt_st.bresp = LTU_RESP_OKAY;
          end
          default: begin
            nxt_st.bresp = LTU_RESP_SLVERR;
          end
        endcase
      end
    end

    // one write outstanding; ready again after the response is taken
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;

    // ==========================================================
    // read channel: data are captured at the address handshake
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      case (s_axi_araddr)
        LTU_OFF_IRQ_EN: begin
          rd_field = st_ff.irq_en;
        end
        LTU_OFF_EVT_EN: begin
          rd_field = st_ff.evt_en;
        end
        LTU_OFF_RISE_EN: begin
          rd_field = st_ff.rise_en;
        end
        LTU_OFF_FALL_EN: begin
          rd_field = st_ff.fall_en;
        end
        LTU_OFF_SOFT_TRIG: begin
          rd_field = st_ff.soft_trig;
        end
        LTU_OFF_PENDING: begin
          rd_field = lif.pend; // RULE_06
        end
        LTU_OFF_LEVEL: begin
          rd_field = lif.level;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
      nxt_st.rvalid = 1'b1;
      // reserved upper bits read as zero
      nxt_st.rdata = LTU_DATA_W'(rd_field);
      nxt_st.rresp = rd_hit ? LTU_RESP_OKAY : LTU_RESP_SLVERR;
    end
    // one read outstanding at a time
    nxt_st.arready = !nxt_st.rvalid;
  end

  // ==========================================================
  // state register: every control bit starts cleared, lines disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0; // RULE_10
      st_ff.rdata <= LTU_CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all from flops here or in the trigger module
  assign line_irq = lif.irq; // RULE_16
  assign line_event = lif.evt; // RULE_17
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

endmodule

`default_nettype wire

// ---- sim/ltu_cpu_model.sv ----
// processor-side model: keeps each line's event pulse until the bench acks it
// assumes events are one-cycle pulses on the shared clock
`timescale 1ns/100ps
`default_nettype none
module ltu_cpu_model #(
  parameter int NL = 19
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NL-1:0] line_event,
  input wire logic ack,
  output logic [NL-1:0] evt_seen
);
  // ==========
  // sticky capture; a pulse landing on the ack edge is kept, not lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_seen <= '0;
    end else begin
      evt_seen <= (ack ? '0 : evt_seen) | line_event;
    end
  end
endmodule
`default_nettype wire

// ---- sim/ltu_top_sva.sv ----
// checker of the line trigger unit: bus handshakes, event pulses, irq hold
// assumes one clock domain and the async active-high reset
`timescale 1ns/100ps
`default_nettype none
module ltu_top_sva #(
  parameter int NL = 19
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NL-1:0] line_in,
  input wire logic [NL-1:0] line_irq,
  input wire logic [NL-1:0] line_event,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ltu_pkg::LTU_DATA_W-1:0] s_axi_rdata
);
  logic [7:0] wr_age;
  logic [7:0] lin_age;
  logic [NL-1:0] lin_q;
  // ==========
  // ages since last write answer and last pin change; saturate, never wrap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_age <= 8'hFF;
      lin_age <= 8'hFF;
      lin_q <= '0;
    end else begin
      wr_age <= s_axi_bvalid ? 8'h00 : wr_age + {7'h00, wr_age != 8'hFF};
      lin_age <= (line_in != lin_q) ? 8'h00 : lin_age + {7'h00, lin_age != 8'hFF};
      lin_q <= line_in;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_evt_single: assert property ((line_event & $past(line_event)) == '0)
    else $error("event pulse too long");
  chk_evt_cause: assert property (line_event != '0 |-> wr_age < 8'h08 || lin_age < 8'h08)
    else $error("event without cause");
  chk_irq_hold: assert property (($past(line_irq) & ~line_irq) != '0 |-> wr_age < 8'h08)
    else $error("irq dropped without write");
  chk_reset_quiet: assert property ($past(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && line_irq == '0)
    else $error("outputs busy after reset");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  cover property (line_event != '0 && lin_age < 8'h08);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (($past(line_irq) & ~line_irq) != '0);
endmodule
bind ltu_top ltu_top_sva #(.NL(NL)) ltu_top_sva_inst (
  .clk(clk), .sys_rst(sys_rst), .line_in(line_in), .line_irq(line_irq), .line_event(line_event),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// ---- sim/tb_ltu_top.sv ----
// testbench of the line trigger unit: AXI4-Lite master, pin stimulus, scoreboard
// assumes ltu_pkg, the unit and the processor-side model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_ltu_top;
  import ltu_pkg::*;
  localparam int NL = LTU_LINES;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic snap = 1'b0;
  logic [NL-1:0] line_in = '0;
  logic [NL-1:0] line_irq, line_event, evt_seen;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] prot = 3'h0;
  logic [31:0] rnd = 32'h13;
  logic [33:0] q[$];
  int error_cnt = 0;
  int n_tests = 0;
  initial forever #5 clk = ~clk;
  ltu_top #(.NL(NL)) ltu_top_inst (
    .clk(clk), .sys_rst(sys_rst), .line_in(line_in), .line_irq(line_irq), .line_event(line_event),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(prot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(prot),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp)
  );
  ltu_cpu_model #(.NL(NL)) ltu_cpu_model_inst (
    .clk(clk), .sys_rst(sys_rst), .line_event(line_event), .ack(snap), .evt_seen(evt_seen)
  );
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(input string s, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // write; the answer is held back a random few cycles to exercise the hold
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    q.push_back({32'h0, (s == LTU_FULL_STRB) ? LTU_RESP_OKAY : LTU_RESP_SLVERR});
    rnd = lfsr(rnd);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat (rnd[1:0]) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    q.push_back({r, e});
    rnd = lfsr(rnd);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (rnd[1:0]) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // let pin or trigger effects settle, then snapshot irq lines and events
  task automatic look(input logic [NL-1:0] irq, input logic [NL-1:0] evt);
    repeat (8) @(posedge clk);
    q.push_back({15'h0, irq});
    q.push_back({15'h0, evt});
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask
  // ==========
  // scoreboard: oldest note against each result as it appears
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", q.pop_front(), {32'h0, s_axi_bresp});
    if (snap) begin
      cmp("line_irq", q.pop_front(), {15'h0, line_irq});
      cmp("events", q.pop_front(), {15'h0, evt_seen});
    end
  end
  // ==========
  // main sequence
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    wr(8'h14, 32'h0007_FFFF);
    rd(8'h1C, 32'h0, LTU_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d = rnd & 32'h0007_FFFF;
      wr(8'(4 * i), d);
      rd(8'(4 * i), d & 32'h0007_FFFF);
    end
    wr(8'h0C, 32'h0000_0001, 4'h3);
    rd(8'h0C, d & 32'h0007_FFFF);
    wr(8'h00, 32'h0007_FFFF);
    wr(8'h04, 32'h0007_FFFF);
    wr(8'h08, 32'h0000_0005);
    wr(8'h0C, 32'h0000_0006);
    wr(8'h14, 32'h0007_FFFF);
    line_in <= '1;
    look(19'h00005, 19'h00005);
    rd(8'h14, 32'h0000_0005);
    rd(8'h18, 32'h0007_FFFF);
    wr(8'h18, 32'h0);
    line_in <= '0;
    look(19'h00007, 19'h00006);
    wr(8'h14, 32'h0000_0001);
    wr(8'h14, 32'h0);
    look(19'h00006, 19'h00000);
    rd(8'h14, 32'h0000_0006);
    wr(8'h00, 32'h0);
    look(19'h00000, 19'h00000);
    wr(8'h14, 32'h0007_FFFF);
    wr(8'h10, 32'h0004_0000);
    look(19'h00000, 19'h40000);
    rd(8'h14, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h0007_FFFF);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h0004_0000);
    look(19'h40000, 19'h00000);
    rd(8'h10, 32'h0004_0000);
    end_of_test();
  end
  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
